// ### hdl/cscx_pkg.sv
// Package: constants for the compare/skip/complement execution block
package cscx_pkg;
    // Opcode field values (upper bits of the 16-bit instruction word)
    localparam logic [6:0] OPC_COMPLEMENT = 7'h07; // 0001 11xx
    localparam logic [6:0] OPC_CMP_EQUAL  = 7'h31; // 0110 001x
    localparam logic [6:0] OPC_CMP_GREAT  = 7'h32; // 0110 010x
    // Field positions
    localparam int          OPC_MSB       = 15;
    localparam int          OPC_LSB_BYTE  = 9;
    localparam int          DEST_BIT      = 9;
    localparam int          ACCESS_BIT    = 8;
    // Indexed literal offset limit
    localparam logic [7:0] LIT_OFS_LIMIT  = 8'h5f;
    // Access bank upper half starts here (low half is bank 0)
    localparam logic [7:0] ACC_HIGH_START = 8'h60;
    localparam logic [3:0] ACC_HIGH_BANK  = 4'hf;
    // Reset values and last phase
    localparam logic [1:0] PHASE_RST      = 2'h0;
    localparam logic [1:0] SKIP_RST       = 2'h0;
    localparam logic [1:0] PHASE_LAST     = 2'h3;
    // Skip cycle counts
    localparam logic [1:0] SKIP_ONE_WORD  = 2'h1;
    localparam logic [1:0] SKIP_TWO_WORD  = 2'h2;

    typedef enum logic [1:0] {
        CSCX_OP_NONE,
        CSCX_OP_COMPLEMENT,
        CSCX_OP_CMP_EQUAL,
        CSCX_OP_CMP_GREAT
    } cscx_op_t;
endpackage : cscx_pkg

// ### hdl/cscx_exec.sv
// Execution unit: complement register and compare-and-skip instructions
//
// Function
// RULE_01: Greater compare subtracts unsigned, changes nothing
// RULE_02: Greater skip only when byte exceeds working
// RULE_03: Taken skip discards fetch, runs one no-op
// RULE_04: Skip over two-word instruction costs three
// RULE_05: Access bit zero selects access bank
// RULE_06: Extended set, low addresses index pointer
// RULE_07: Complement decodes, reads, processes, writes per phase
// RULE_08: Compare decodes, reads, compares, never writes
// RULE_09: Equal skip only when byte equals working
// RULE_10: Complement result is bitwise inversion
// RULE_11: Access bit one uses bank select register
// RULE_12: Destination zero writes working, source unchanged
`timescale 1ns/100ps
`default_nettype none

module cscx_exec #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 12
) (
    input  wire logic                 clk_i,
    input  wire logic                 sys_rst_i,
    input  wire logic                 phase_en_i,
    input  wire logic [15:0]          instr_i,
    input  wire logic                 instr_valid_i,
    input  wire logic                 next_two_word_i,
    input  wire logic                 ext_set_en_i,
    input  wire logic [3:0]           bank_select_register_i,
    input  wire logic [ADDR_W-1:0]    index_ptr_i,
    input  wire logic [DATA_W-1:0]    working_register_i,
    input  wire logic [DATA_W-1:0]    mem_rdata_i,
    output logic      [ADDR_W-1:0]    mem_addr_o,
    output logic                      mem_rd_o,
    output logic                      mem_wr_o,
    output logic      [DATA_W-1:0]    mem_wdata_o,
    output logic                      working_wr_o,
    output logic      [DATA_W-1:0]    working_wdata_o,
    output logic                      flush_o,
    output logic                      nop_cycle_o,
    output logic      [1:0]           phase_o
);
    import cscx_pkg::*;

    // Refuse widths the byte datapath and 12-bit space cannot serve
    initial begin
        if (DATA_W != 8 || ADDR_W != 12) begin
            $error("cscx_exec supports only 8-bit data, 12-bit address");
        end
    end

    // Address forming shared by all three instructions
    function automatic logic [11:0] form_addr(input logic [7:0] f, input logic acc,
                                              input logic ext, input logic [3:0] bank,
                                              input logic [11:0] ptr);
        logic [11:0] a;
        a = {bank, f};                                // [RULE_11]
        if (!acc) begin
            if (ext && f <= LIT_OFS_LIMIT) begin
                a = 12'(ptr + {4'h0, f});             // [RULE_06]
            end else if (f >= ACC_HIGH_START) begin
                a = {ACC_HIGH_BANK, f};               // [RULE_05]
            end else begin
                a = {4'h0, f};                        // [RULE_05]
            end
        end
        return a;
    endfunction : form_addr

    // ------------------------------------------------------------
    // Phase sequencing
    // ------------------------------------------------------------
    // Phase count and one-clock strobes, one per quarter
    logic [1:0] phase_q;
    logic       q1, q2, q3, q4;
    assign q1 = phase_en_i && phase_q == 2'h0;
    assign q2 = phase_en_i && phase_q == 2'h1;
    assign q3 = phase_en_i && phase_q == 2'h2;
    assign q4 = phase_en_i && phase_q == PHASE_LAST;
    assign phase_o = phase_q;

    // Phase counter, one step per enable
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            phase_q <= PHASE_RST;
        end else if (phase_en_i) begin
            phase_q <= 2'(phase_q + 2'h1);
        end
    end

    // ------------------------------------------------------------
    // Decode (Q1)
    // ------------------------------------------------------------
    // Decoded instruction, held for its whole cycle
    cscx_op_t    op_q;
    logic [11:0] addr_q;
    logic        dest_q;
    logic [1:0]  skip_q;
    cscx_op_t    op_d;

    // Opcode match on the upper instruction bits; others stay idle
    always_comb begin
        op_d = CSCX_OP_NONE;
        if (instr_i[OPC_MSB:10] == OPC_COMPLEMENT[5:0]) begin
            op_d = CSCX_OP_COMPLEMENT;
        end else if (instr_i[OPC_MSB:OPC_LSB_BYTE] == OPC_CMP_EQUAL) begin
            op_d = CSCX_OP_CMP_EQUAL;
        end else if (instr_i[OPC_MSB:OPC_LSB_BYTE] == OPC_CMP_GREAT) begin
            op_d = CSCX_OP_CMP_GREAT;
        end
    end

    // Latch decoded op unless this cycle is a skipped no-op or no valid word is offered
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            op_q   <= CSCX_OP_NONE;
            addr_q <= 12'h000;
            dest_q <= 1'b0;
        end else if (q1) begin
            op_q   <= (skip_q != SKIP_RST || !instr_valid_i) ? CSCX_OP_NONE : op_d;
            addr_q <= form_addr(instr_i[7:0], instr_i[ACCESS_BIT], ext_set_en_i,
                                bank_select_register_i, index_ptr_i);
            dest_q <= instr_i[DEST_BIT];
        end
    end

    // ------------------------------------------------------------
    // Read (Q2) and process (Q3)
    // ------------------------------------------------------------
    // Operand, inverted result and skip decision
    logic [7:0] opnd_q;
    logic [7:0] result_q;
    logic       take_q;
    logic [8:0] diff;
    // Unsigned subtraction; operands untouched, no flags driven
    assign diff = {1'b0, opnd_q} - {1'b0, working_register_i};   // [RULE_01]

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            opnd_q <= 8'h00;
        end else if (q2 && op_q != CSCX_OP_NONE) begin
            opnd_q <= mem_rdata_i;                    // [RULE_07] [RULE_08]
        end
    end

    // Process in Q3: invert or compare
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            result_q <= 8'h00;
            take_q   <= 1'b0;
        end else if (q3) begin
            result_q <= ~opnd_q;                      // [RULE_10]
            case (op_q)
                CSCX_OP_CMP_EQUAL: take_q <= diff == 9'h000;             // [RULE_09]
                CSCX_OP_CMP_GREAT: take_q <= !diff[8] && diff != 9'h000; // [RULE_02]
                default:           take_q <= 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Write (Q4) and skip bookkeeping
    // ------------------------------------------------------------
    // Write strobes for the two destinations
    logic wr_mem, wr_w;
    // Compares never write in Q4
    assign wr_mem = q4 && op_q == CSCX_OP_COMPLEMENT && dest_q;   // [RULE_07] [RULE_08]
    assign wr_w   = q4 && op_q == CSCX_OP_COMPLEMENT && !dest_q;  // [RULE_12]

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mem_wr_o        <= 1'b0;
            working_wr_o    <= 1'b0;
            mem_wdata_o     <= 8'h00;
            working_wdata_o <= 8'h00;
        end else begin
            mem_wr_o     <= wr_mem;
            working_wr_o <= wr_w;
            if (wr_mem) begin
                mem_wdata_o <= result_q;
            end
            if (wr_w) begin
                working_wdata_o <= result_q;          // [RULE_12]
            end
        end
    end

    // Count of instruction cycles to be run as no-ops
    // Reset or the last no-op cycle returns it to idle
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            skip_q <= SKIP_RST;
        end else if (q4) begin
            if (take_q && op_q != CSCX_OP_NONE) begin
                skip_q <= next_two_word_i ? SKIP_TWO_WORD : SKIP_ONE_WORD; // [RULE_03] [RULE_04]
            end else if (skip_q != SKIP_RST) begin
                skip_q <= 2'(skip_q - 2'h1);
            end
        end
    end

    // Flush pulse at end of a taken compare cycle
    // Tells the fetch side to drop the word already fetched
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flush_o <= 1'b0;
        end else begin
            flush_o <= q4 && take_q && op_q != CSCX_OP_NONE;  // [RULE_03]
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Whole-cycle no-op indicator; a skipped fetch is never read
    assign nop_cycle_o = skip_q != SKIP_RST;                  // [RULE_04]
    // Operand address and read strobe for the data space
    assign mem_addr_o  = addr_q;
    assign mem_rd_o    = phase_q == 2'h1 && op_q != CSCX_OP_NONE;
endmodule : cscx_exec

`default_nettype wire

// ### tb/cscx_exec_chk.sv
// Checker: timing of reads, writes, flush and no-op cycles
`timescale 1ns/100ps
`default_nettype none
module cscx_exec_chk #(
    parameter int ADDR_W = 12
) (
    input wire logic              clk_i,
    input wire logic              sys_rst_i,
    input wire logic              phase_en_i,
    input wire logic [ADDR_W-1:0] mem_addr_o,
    input wire logic              mem_rd_o,
    input wire logic              mem_wr_o,
    input wire logic              working_wr_o,
    input wire logic              flush_o,
    input wire logic              nop_cycle_o,
    input wire logic [1:0]        phase_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // One skipped instruction lasts at least four clocks
    sequence s_nop_cycle;
        nop_cycle_o [*4];
    endsequence
    // Operand read, write and skip timing
    a_read_in_q2: assert property (mem_rd_o |-> phase_o == 2'h1)
        else $error("read outside second phase");
    a_read_once: assert property (mem_rd_o && phase_en_i |=> !mem_rd_o)
        else $error("read longer than one phase");
    a_addr_hold: assert property (mem_rd_o && phase_en_i |=> $stable(mem_addr_o))
        else $error("address moved after read");
    a_wr_exclusive: assert property (!(mem_wr_o && working_wr_o))
        else $error("two destinations written");
    a_flush_no_wr: assert property (flush_o |-> !mem_wr_o && !working_wr_o)
        else $error("compare wrote a result");
    a_flush_pulse: assert property (flush_o |=> !flush_o)
        else $error("flush longer than one clock");
    a_flush_to_nop: assert property (flush_o |-> ##[0:4] nop_cycle_o)
        else $error("flush without no-op cycle");
    a_nop_span: assert property ($rose(nop_cycle_o) |-> s_nop_cycle)
        else $error("no-op cycle cut short");
    a_nop_no_read: assert property (nop_cycle_o |-> !mem_rd_o)
        else $error("operand read in a skipped cycle");
endmodule : cscx_exec_chk
bind cscx_exec cscx_exec_chk #(.ADDR_W(ADDR_W)) u_cscx_exec_chk (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .phase_en_i(phase_en_i), .mem_addr_o(mem_addr_o),
    .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .working_wr_o(working_wr_o),
    .flush_o(flush_o), .nop_cycle_o(nop_cycle_o), .phase_o(phase_o));
`default_nettype wire

// ### tb/cscx_exec_tb.sv
// Testbench: instruction table, then two-word skip, refused instruction, half-rate enable and mid-run reset cases
`timescale 1ns/100ps
`default_nettype none
module cscx_exec_tb;
    typedef struct {logic [15:0] i; logic [7:0] w, r; logic x; logic [11:0] a;
                    logic [1:0] k;} cscx_row_t;
    logic        clk_i = 1'b0, sys_rst_i = 1'b1, vld = 1'b0, two = 1'b0, ext = 1'b0;
    logic        pen = 1'b1, slow = 1'b0;
    logic [15:0] ins = 16'h0000;
    logic [7:0]  w = 8'h00, rd = 8'h00, wd, wwd, dat;
    logic [11:0] adr, sa;
    logic [1:0]  ph;
    logic        mwr, wwr, fl, nop, mrd;
    int          mismatches = 0, tests_run = 0, nw, nk, nf, nn;
    // Kind: 0 none, 1 register write, 2 working write, 3 skip
    cscx_row_t rows [7] = '{'{16'h1c13, 8'h00, 8'h13, 1'b0, 12'h013, 2'h2},
        '{16'h1fa5, 8'h00, 8'h0f, 1'b0, 12'h5a5, 2'h1},
        '{16'h6270, 8'h33, 8'h33, 1'b0, 12'hf70, 2'h3},
        '{16'h6310, 8'h33, 8'h34, 1'b0, 12'h510, 2'h0},
        '{16'h6405, 8'h7f, 8'h81, 1'b1, 12'h3f5, 2'h3},
        '{16'h6460, 8'h40, 8'h40, 1'b1, 12'hf60, 2'h0},
        '{16'h645f, 8'h80, 8'h7f, 1'b1, 12'h44f, 2'h0}};
    cscx_exec u_cscx_exec (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .phase_en_i(pen),
        .instr_i(ins), .instr_valid_i(vld), .next_two_word_i(two), .ext_set_en_i(ext),
        .bank_select_register_i(4'h5), .index_ptr_i(12'h3f0), .working_register_i(w),
        .mem_rdata_i(rd), .mem_addr_o(adr), .mem_rd_o(mrd), .mem_wr_o(mwr),
        .mem_wdata_o(wd), .working_wr_o(wwr), .working_wdata_o(wwd), .flush_o(fl),
        .nop_cycle_o(nop), .phase_o(ph));
    always #10 clk_i = ~clk_i;
    // Phase enable: every clock, or every other clock in slow mode
    always @(negedge clk_i) pen <= slow ? ~pen : 1'b1;
    task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run
    // Offer one instruction and hold it until its Q1 edge has passed
    task automatic issue(input logic [15:0] i);
        int n;
        n = 0;
        while (ph !== 2'h0) begin
            @(negedge clk_i);
            n++;
            if (n > 16) begin
                mismatches++;
                complete_run();
            end
        end
        ins = i;
        vld = 1'b1;
        while (ph === 2'h0) begin
            @(negedge clk_i);
            n++;
            if (n > 16) begin
                mismatches++;
                complete_run();
            end
        end
        vld = 1'b0;
    endtask : issue
    // Issue one instruction, then tally the outputs it causes
    task automatic exec(input logic [15:0] i, input logic [7:0] wv, rv);
        {nw, nk, nf, nn, sa, dat} = '0;
        w = wv;
        rd = rv;
        issue(i);
        repeat (28) begin
            if (mrd === 1'b1) sa = adr;
            if (mwr === 1'b1) begin
                nw++;
                dat = wd;
            end
            if (wwr === 1'b1) begin
                nk++;
                dat = wwd;
            end
            nf += int'(fl === 1'b1);
            nn += int'(nop === 1'b1);
            @(negedge clk_i);
        end
    endtask : exec
    initial begin
        repeat (12) @(negedge clk_i);
        check("reset outputs", 16'({ph, mwr, wwr, fl, nop, mrd}), 16'h0000);
        sys_rst_i = 1'b0;
        foreach (rows[j]) begin
            ext = rows[j].x;
            exec(rows[j].i, rows[j].w, rows[j].r);
            check("address", 16'(sa), 16'(rows[j].a));
            check("reg writes", 16'(nw), 16'(rows[j].k == 2'h1));
            check("w writes", 16'(nk), 16'(rows[j].k == 2'h2));
            check("flush", 16'(nf), 16'(rows[j].k == 2'h3));
            check("nop clocks", 16'(nn), rows[j].k == 2'h3 ? 16'h4 : 16'h0);
            if (rows[j].k inside {2'h1, 2'h2})
                check("result", {8'h00, dat}, {8'h00, ~rows[j].r});
            $display("row %0d done", j);
        end
        // Skip landing on a two-word instruction
        ext = 1'b0;
        two = 1'b1;
        exec(16'h6270, 8'h5a, 8'h5a);
        check("two-word nop clocks", 16'(nn), 16'h8);
        check("two-word flush", 16'(nf), 16'h1);
        $display("two-word skip done");
        two = 1'b0;
        // Instruction offered in a skipped cycle is dropped
        w = 8'h22;
        rd = 8'h22;
        issue(16'h6270);
        exec(16'h1fa5, 8'h22, 8'h22);
        check("refused reg writes", 16'(nw), 16'h0);
        check("refused w writes", 16'(nk), 16'h0);
        $display("refused instruction done");
        // Half-rate phase enable: eight clocks per instruction cycle
        slow = 1'b1;
        exec(16'h1fa5, 8'h00, 8'h0f);
        check("slow address", 16'(sa), 16'h05a5);
        check("slow reg writes", 16'(nw), 16'h1);
        check("slow result", {8'h00, dat}, 16'h00f0);
        exec(16'h6270, 8'h5a, 8'h5a);
        check("slow nop clocks", 16'(nn), 16'h8);
        check("slow flush", 16'(nf), 16'h1);
        slow = 1'b0;
        $display("half-rate enable done");
        // Reset in mid-run, inside a skipped cycle
        w = 8'h11;
        rd = 8'h11;
        issue(16'h6270);
        repeat (4) @(negedge clk_i);
        check("nop before reset", 16'(nop), 16'h1);
        sys_rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        check("mid-run reset outputs", 16'({ph, mwr, wwr, fl, nop, mrd}), 16'h0000);
        sys_rst_i = 1'b0;
        exec(16'h1c13, 8'h00, 8'h3c);
        check("after reset w writes", 16'(nk), 16'h1);
        check("after reset result", {8'h00, dat}, 16'h00c3);
        check("after reset nop clocks", 16'(nn), 16'h0);
        $display("mid-run reset done");
        complete_run();
    end
endmodule : cscx_exec_tb
`default_nettype wire
